/* core/uart_once_pkg.sv */
package uart_once_pkg;

    // link timing
    localparam int         CLK_HZ    = 10_000_000;
    localparam int         BAUD_BPS  = 57600;
    localparam logic [7:0] BIT_CYC   = 8'(CLK_HZ / BAUD_BPS);
    localparam logic [7:0] BIT_LAST  = BIT_CYC - 8'h01;
    localparam logic [7:0] HALF_LAST = (BIT_CYC >> 1) - 8'h01;

    // frame format
    localparam logic [3:0] DATA_LAST = 4'h7;
    localparam logic [3:0] STOP_LAST = 4'h1;

    // message
    localparam logic [3:0] MSG_LEN  = 4'hC;
    localparam logic [3:0] MSG_LAST = MSG_LEN - 4'h1;
    localparam logic [7:0] TX_MSG [12] = '{
        8'h48, 8'h65, 8'h6C, 8'h6C, 8'h6F, 8'h20,
        8'h77, 8'h6F, 8'h72, 8'h6C, 8'h64, 8'h21
    };

    // channel instances 1, 5, 6, 8, 9 map to select index 0..4
    localparam int         NUM_CH     = 5;
    localparam logic [2:0] CH_DEFAULT = 3'h0;
    localparam logic [2:0] CH_MAX     = 3'h4;

    // register byte addresses
    localparam logic [11:0] ADDR_CTRL    = 12'h000;
    localparam logic [11:0] ADDR_STATUS  = 12'h004;
    localparam logic [11:0] ADDR_INT_STS = 12'h008;
    localparam logic [11:0] ADDR_INT_MSK = 12'h00C;
    localparam logic [11:0] ADDR_RXBUF0  = 12'h010;
    localparam logic [11:0] ADDR_RXBUF2  = 12'h018;

    // field positions
    localparam int CTRL_START_BIT = 8;
    localparam int ST_TX_DONE     = 0;
    localparam int ST_RX_DONE     = 1;
    localparam int ST_RX_ERR      = 2;
    localparam int ST_TX_BUSY     = 3;
    localparam int ST_RX_BUSY     = 4;
    localparam int ST_FRAME_ERR   = 5;
    localparam int ST_OVERRUN     = 6;
    localparam int ST_STARTED     = 7;
    localparam int ST_COUNT_LSB   = 8;
    localparam int IRQ_W          = 3;

    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;

endpackage

/* core/serial_tx.sv */
`timescale 1ns/100ps
`default_nettype none
module serial_tx (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // byte request
    input  wire logic       load,
    input  wire logic [7:0] data,
    output logic            busy,
    output logic            done,
    // line
    output logic            txd
);
    uart_once_pkg::tx_state_t state_r, state_nxt;
    logic [7:0] cyc_r, cyc_nxt;
    logic [3:0] bit_r, bit_nxt;
    logic [7:0] shift_r, shift_nxt;
    logic       txd_r, txd_nxt;

    assign busy = (state_r != uart_once_pkg::TX_IDLE);
    assign txd  = txd_r;

    always_comb begin
        state_nxt = state_r;
        cyc_nxt   = cyc_r + 8'h01;
        bit_nxt   = bit_r;
        shift_nxt = shift_r;
        txd_nxt   = txd_r;
        done      = 1'b0;
        case (state_r)
            uart_once_pkg::TX_IDLE: begin
                cyc_nxt = 8'h00;
                txd_nxt = 1'b1;
                if (load) begin
                    state_nxt = uart_once_pkg::TX_START;
                    shift_nxt = data;
                    txd_nxt   = 1'b0;
                end
            end
            uart_once_pkg::TX_START: begin
                if (cyc_r == uart_once_pkg::BIT_LAST) begin
                    cyc_nxt   = 8'h00;
                    bit_nxt   = 4'h0;
                    state_nxt = uart_once_pkg::TX_DATA;
                    txd_nxt   = shift_r[0];
                end
            end
            uart_once_pkg::TX_DATA: begin
                if (cyc_r == uart_once_pkg::BIT_LAST) begin
                    cyc_nxt = 8'h00;
                    if (bit_r == uart_once_pkg::DATA_LAST) begin
                        bit_nxt   = 4'h0;
                        state_nxt = uart_once_pkg::TX_STOP;
                        txd_nxt   = 1'b1;
                    end else begin
                        bit_nxt   = bit_r + 4'h1;
                        shift_nxt = {1'b0, shift_r[7:1]};
                        txd_nxt   = shift_r[1];
                    end
                end
            end
            uart_once_pkg::TX_STOP: begin
                if (cyc_r == uart_once_pkg::BIT_LAST) begin
                    cyc_nxt = 8'h00;
                    if (bit_r == uart_once_pkg::STOP_LAST) begin
                        state_nxt = uart_once_pkg::TX_IDLE;
                        done      = 1'b1;
                    end else begin
                        bit_nxt = bit_r + 4'h1;
                    end
                end
            end
            default: state_nxt = uart_once_pkg::TX_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= uart_once_pkg::TX_IDLE;
            cyc_r   <= 8'h00;
            bit_r   <= 4'h0;
            shift_r <= 8'h00;
            txd_r   <= 1'b1;
        end else begin
            state_r <= state_nxt;
            cyc_r   <= cyc_nxt;
            bit_r   <= bit_nxt;
            shift_r <= shift_nxt;
            txd_r   <= txd_nxt;
        end
    end
endmodule
`default_nettype wire

/* core/serial_rx.sv */
`timescale 1ns/100ps
`default_nettype none
module serial_rx (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // control
    input  wire logic       en,
    input  wire logic       rxd,
    // received byte
    output logic [7:0]      data,
    output logic            full,
    input  wire logic       ack,
    // errors, one-cycle pulses
    output logic            frame_err,
    output logic            overrun
);
    uart_once_pkg::rx_state_t state_r, state_nxt;
    logic [7:0] cyc_r, cyc_nxt;
    logic [3:0] bit_r, bit_nxt;
    logic [7:0] shift_r, shift_nxt;
    logic [7:0] data_r, data_nxt;
    logic       full_r, full_nxt;

    assign data = data_r;
    assign full = full_r;

    always_comb begin
        state_nxt = state_r;
        cyc_nxt   = cyc_r + 8'h01;
        bit_nxt   = bit_r;
        shift_nxt = shift_r;
        data_nxt  = data_r;
        full_nxt  = full_r & ~ack;
        frame_err = 1'b0;
        overrun   = 1'b0;
        case (state_r)
            uart_once_pkg::RX_IDLE: begin
                cyc_nxt = 8'h00;
                if (!rxd)
                    state_nxt = uart_once_pkg::RX_START;
            end
            uart_once_pkg::RX_START: begin
                if (cyc_r == uart_once_pkg::HALF_LAST) begin
                    cyc_nxt = 8'h00;
                    bit_nxt = 4'h0;
                    // a glitch that is high again at mid bit is no start
                    state_nxt = rxd ? uart_once_pkg::RX_IDLE
                                    : uart_once_pkg::RX_DATA;
                end
            end
            uart_once_pkg::RX_DATA: begin
                if (cyc_r == uart_once_pkg::BIT_LAST) begin
                    cyc_nxt   = 8'h00;
                    shift_nxt = {rxd, shift_r[7:1]};
                    if (bit_r == uart_once_pkg::DATA_LAST) begin
                        bit_nxt   = 4'h0;
                        state_nxt = uart_once_pkg::RX_STOP;
                    end else begin
                        bit_nxt = bit_r + 4'h1;
                    end
                end
            end
            uart_once_pkg::RX_STOP: begin
                if (cyc_r == uart_once_pkg::BIT_LAST) begin
                    cyc_nxt = 8'h00;
                    if (!rxd) begin
                        frame_err = 1'b1;
                        state_nxt = uart_once_pkg::RX_IDLE;
                    end else if (bit_r == uart_once_pkg::STOP_LAST) begin
                        state_nxt = uart_once_pkg::RX_IDLE;
                        if (full_r && !ack) begin
                            overrun = 1'b1;
                        end else begin
                            data_nxt = shift_r;
                            full_nxt = 1'b1;
                        end
                    end else begin
                        bit_nxt = bit_r + 4'h1;
                    end
                end
            end
            default: state_nxt = uart_once_pkg::RX_IDLE;
        endcase
        if (!en) begin
            state_nxt = uart_once_pkg::RX_IDLE;
            frame_err = 1'b0;
            overrun   = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= uart_once_pkg::RX_IDLE;
            cyc_r   <= 8'h00;
            bit_r   <= 4'h0;
            shift_r <= 8'h00;
            data_r  <= 8'h00;
            full_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cyc_r   <= cyc_nxt;
            bit_r   <= bit_nxt;
            shift_r <= shift_nxt;
            data_r  <= data_nxt;
            full_r  <= full_nxt;
        end
    end
endmodule
`default_nettype wire

/* core/async_serial_once_demo.sv */
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
module async_serial_once_demo (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // channel pins, index 0..4 = channel 1,5,6,8,9
    input  wire logic [4:0]  rxd_pin,
    output logic [4:0]       txd_pin,
    output logic [4:0]       txd_pin_oe,
    // general-purpose drive for pins of unselected channels
    input  wire logic [4:0]  gpio_out,
    input  wire logic [4:0]  gpio_oe,
    // indicators and interrupt
    output logic             tx_done_indicator,
    output logic             rx_done_indicator,
    output logic             rx_error_indicator,
    output logic             irq
);
    localparam int IRQW = uart_once_pkg::IRQ_W;

    logic [2:0]  sel_r, sel_nxt;
    logic        started_r, started_nxt;
    logic        tx_act_r, tx_act_nxt;
    logic        rx_act_r, rx_act_nxt;
    logic [3:0]  tx_idx_r, tx_idx_nxt;
    logic [3:0]  rx_idx_r, rx_idx_nxt;
    logic        tx_done_r, tx_done_nxt;
    logic        rx_done_r, rx_done_nxt;
    logic        rx_err_r, rx_err_nxt;
    logic        ferr_r, ferr_nxt;
    logic        ovr_r, ovr_nxt;
    logic [IRQW-1:0] int_sts_r, int_sts_nxt;
    logic [IRQW-1:0] int_msk_r, int_msk_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic        pslverr_r, pslverr_nxt;
    logic [7:0]  rx_mem [12];

    logic        tx_load;
    logic        tx_busy;
    logic        tx_byte_done;
    logic        txd;
    logic        rxd;
    logic [7:0]  rx_data;
    logic        rx_full;
    logic        rx_ack;
    logic        rx_ferr;
    logic        rx_ovr;
    logic        wr_en;
    logic        setup;
    logic        addr_ok;
    logic        tx_finish;
    logic        rx_finish;
    logic        rx_fail;
    logic [IRQW-1:0] events;

    // transmit: once started, feed the greeting one byte whenever the shifter is idle, until all 12 are loaded
    assign tx_load = tx_act_r && !tx_busy
                     && (tx_idx_r != uart_once_pkg::MSG_LEN);
    assign tx_finish = tx_byte_done
                       && (tx_idx_r == uart_once_pkg::MSG_LEN);

    serial_tx u_tx (
        .pclk    (pclk),
        .presetn (presetn),
        .load    (tx_load),
        .data    (uart_once_pkg::TX_MSG[tx_idx_r]),
        .busy    (tx_busy),
        .done    (tx_byte_done),
        .txd     (txd)
    );

    // receive: only the selected channel's input reaches the shifter
    assign rxd    = rxd_pin[sel_r];
    assign rx_ack = rx_full && rx_act_r;
    assign rx_fail   = rx_act_r && (rx_ferr || rx_ovr);
    assign rx_finish = rx_ack && !rx_fail
                       && (rx_idx_r == uart_once_pkg::MSG_LAST);

    serial_rx u_rx (
        .pclk      (pclk),
        .presetn   (presetn),
        .en        (rx_act_r),
        .rxd       (rxd),
        .data      (rx_data),
        .full      (rx_full),
        .ack       (rx_ack),
        .frame_err (rx_ferr),
        .overrun   (rx_ovr)
    );

    // pin steering, only txd and rxd are used on the link
    genvar ch;
    generate
        for (ch = 0; ch < uart_once_pkg::NUM_CH; ch++) begin : g_pin
            always_comb begin
                if (sel_r == 3'(ch)) begin
                    txd_pin[ch]    = txd;
                    txd_pin_oe[ch] = 1'b1;
                end else begin
                    txd_pin[ch]    = gpio_out[ch];
                    txd_pin_oe[ch] = gpio_oe[ch];
                end
            end
        end
    endgenerate

    // bus decode
    assign setup   = psel && !penable;
    assign wr_en   = psel && penable && pwrite;
    assign pready  = 1'b1;
    assign prdata  = prdata_r;
    assign pslverr = pslverr_r;
    assign addr_ok = (paddr[1:0] == 2'h0)
                     && (paddr <= uart_once_pkg::ADDR_RXBUF2);

    assign events[uart_once_pkg::ST_TX_DONE] = tx_finish;
    assign events[uart_once_pkg::ST_RX_DONE] = rx_finish;
    assign events[uart_once_pkg::ST_RX_ERR]  = rx_fail;

    always_comb begin
        sel_nxt     = sel_r;
        started_nxt = started_r;
        tx_act_nxt  = tx_act_r;
        rx_act_nxt  = rx_act_r;
        tx_idx_nxt  = tx_idx_r;
        rx_idx_nxt  = rx_idx_r;
        tx_done_nxt = tx_done_r;
        rx_done_nxt = rx_done_r;
        rx_err_nxt  = rx_err_r;
        ferr_nxt    = ferr_r | (rx_act_r & rx_ferr);
        ovr_nxt     = ovr_r | (rx_act_r & rx_ovr);
        int_msk_nxt = int_msk_r;
        int_sts_nxt = int_sts_r;

        if (wr_en && paddr == uart_once_pkg::ADDR_CTRL && !started_r) begin
            // channel is frozen once traffic may have begun
            if (pwdata[2:0] <= uart_once_pkg::CH_MAX)
                sel_nxt = pwdata[2:0];
            if (pwdata[uart_once_pkg::CTRL_START_BIT]) begin
                started_nxt = 1'b1;
                tx_act_nxt  = 1'b1;
                rx_act_nxt  = 1'b1;
            end
        end
        if (wr_en && paddr == uart_once_pkg::ADDR_INT_MSK)
            int_msk_nxt = pwdata[IRQW-1:0];
        if (wr_en && paddr == uart_once_pkg::ADDR_INT_STS)
            int_sts_nxt = int_sts_r & ~pwdata[IRQW-1:0];
        int_sts_nxt = int_sts_nxt | events;

        if (tx_load)
            tx_idx_nxt = tx_idx_r + 4'h1;
        if (tx_finish) begin
            tx_act_nxt  = 1'b0;
            tx_done_nxt = 1'b1;
        end

        if (rx_fail) begin
            rx_act_nxt = 1'b0;
            rx_err_nxt = 1'b1;
        end else if (rx_ack) begin
            rx_idx_nxt = rx_idx_r + 4'h1;
            if (rx_finish) begin
                rx_act_nxt  = 1'b0;
                rx_done_nxt = 1'b1;
            end
        end
    end

    // read data is prepared in the setup phase
    always_comb begin
        prdata_nxt  = prdata_r;
        pslverr_nxt = 1'b0;
        if (setup) begin
            prdata_nxt  = 32'h0000_0000;
            pslverr_nxt = !addr_ok;
            case (paddr)
                uart_once_pkg::ADDR_CTRL:
                    prdata_nxt[2:0] = sel_r;
                uart_once_pkg::ADDR_STATUS: begin
                    prdata_nxt[uart_once_pkg::ST_TX_DONE]   = tx_done_r;
                    prdata_nxt[uart_once_pkg::ST_RX_DONE]   = rx_done_r;
                    prdata_nxt[uart_once_pkg::ST_RX_ERR]    = rx_err_r;
                    prdata_nxt[uart_once_pkg::ST_TX_BUSY]   = tx_act_r;
                    prdata_nxt[uart_once_pkg::ST_RX_BUSY]   = rx_act_r;
                    prdata_nxt[uart_once_pkg::ST_FRAME_ERR] = ferr_r;
                    prdata_nxt[uart_once_pkg::ST_OVERRUN]   = ovr_r;
                    prdata_nxt[uart_once_pkg::ST_STARTED]   = started_r;
                    prdata_nxt[uart_once_pkg::ST_COUNT_LSB +: 4] = rx_idx_r;
                end
                uart_once_pkg::ADDR_INT_STS:
                    prdata_nxt[IRQW-1:0] = int_sts_r;
                uart_once_pkg::ADDR_INT_MSK:
                    prdata_nxt[IRQW-1:0] = int_msk_r;
                default: begin
                    if (addr_ok && paddr >= uart_once_pkg::ADDR_RXBUF0) begin
                        for (int b = 0; b < 4; b++) begin
                            prdata_nxt[8*b +: 8] =
                                rx_mem[4*int'(paddr[3:2]) + b];
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_r     <= uart_once_pkg::CH_DEFAULT;
            started_r <= 1'b0;
            tx_act_r  <= 1'b0;
            rx_act_r  <= 1'b0;
            tx_idx_r  <= 4'h0;
            rx_idx_r  <= 4'h0;
            tx_done_r <= 1'b0;
            rx_done_r <= 1'b0;
            rx_err_r  <= 1'b0;
            ferr_r    <= 1'b0;
            ovr_r     <= 1'b0;
            int_sts_r <= '0;
            int_msk_r <= '0;
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else begin
            sel_r     <= sel_nxt;
            started_r <= started_nxt;
            tx_act_r  <= tx_act_nxt;
            rx_act_r  <= rx_act_nxt;
            tx_idx_r  <= tx_idx_nxt;
            rx_idx_r  <= rx_idx_nxt;
            tx_done_r <= tx_done_nxt;
            rx_done_r <= rx_done_nxt;
            rx_err_r  <= rx_err_nxt;
            ferr_r    <= ferr_nxt;
            ovr_r     <= ovr_nxt;
            int_sts_r <= int_sts_nxt;
            int_msk_r <= int_msk_nxt;
            prdata_r  <= prdata_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    // receive buffer, no reset needed on data
    always_ff @(posedge pclk) begin
        if (rx_ack && !rx_fail)
            rx_mem[rx_idx_r] <= rx_data;
    end

    assign tx_done_indicator  = tx_done_r;
    assign rx_done_indicator  = rx_done_r;
    assign rx_error_indicator = rx_err_r;
    assign irq = |(int_sts_r & int_msk_r);
endmodule
`default_nettype wire

/* bench/async_serial_once_demo_properties.sv */
`timescale 1ns/100ps
`default_nettype none
module async_serial_once_demo_properties (
    // clock and reset
    input wire logic       pclk,
    input wire logic       presetn,
    // pins
    input wire logic [4:0] txd_pin,
    input wire logic [4:0] txd_pin_oe,
    input wire logic [4:0] gpio_out,
    input wire logic [4:0] gpio_oe,
    // indicators
    input wire logic       tx_done_indicator,
    input wire logic       rx_done_indicator,
    input wire logic       rx_error_indicator
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // pin 0 driven while gpio does not enable it: it is the serial channel
    logic       ch0;
    logic [4:0] diff;
    assign ch0 = txd_pin_oe[0] & ~gpio_oe[0];
    assign diff = (txd_pin ^ gpio_out) | (txd_pin_oe ^ gpio_oe);
    sequence s_start_fall;
        $fell(txd_pin[0]) && ch0;
    endsequence
    sequence s_start_low;
        (!txd_pin[0])[*8];
    endsequence
    a_tx_done_sticky: assert property (tx_done_indicator |=> tx_done_indicator)
        else $error("tx done dropped");
    a_rx_done_sticky: assert property (rx_done_indicator |=> rx_done_indicator)
        else $error("rx done dropped");
    a_err_sticky: assert property (rx_error_indicator |=> rx_error_indicator)
        else $error("rx error dropped");
    a_err_not_done: assert property (!(rx_error_indicator && rx_done_indicator))
        else $error("error and done both lit");
    a_gpio_passthru: assert property (((~txd_pin_oe) & (diff | gpio_oe)) == 5'h00)
        else $error("undriven pin not following gpio");
    a_one_serial_pin: assert property ($countones(diff) <= 1)
        else $error("more than one pin taken");
    a_idle_after_reset: assert property ($rose(presetn) |-> txd_pin[0] && txd_pin_oe[0])
        else $error("line not idle high after reset");
    a_start_bit_low: assert property (s_start_fall |-> s_start_low)
        else $error("start bit too short");
    a_quiet_after_done: assert property (tx_done_indicator && ch0 |-> txd_pin[0])
        else $error("traffic after transmit done");
endmodule
bind async_serial_once_demo async_serial_once_demo_properties i_props (
    .pclk(pclk), .presetn(presetn), .txd_pin(txd_pin),
    .txd_pin_oe(txd_pin_oe), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .tx_done_indicator(tx_done_indicator),
    .rx_done_indicator(rx_done_indicator),
    .rx_error_indicator(rx_error_indicator)
);
`default_nettype wire

/* bench/serial_terminal.sv */
`timescale 1ns/100ps
`default_nettype none
module serial_terminal (
    // clock
    input  wire logic pclk,
    // data lines only, no flow control
    input  wire logic txd,
    input  wire logic listen,
    output logic      rxd
);
    localparam int BIT = int'(uart_once_pkg::BIT_CYC);
    logic [7:0] got_q [$];
    logic [7:0] v;
    int         bad = 0;
    initial rxd = 1'b1;
    task automatic send(input logic [7:0] b, input logic stop_ok);
        @(posedge pclk);
        rxd <= 1'b0;
        repeat (BIT) @(posedge pclk);
        for (int i = 0; i < 8; i++) begin
            rxd <= b[i];
            repeat (BIT) @(posedge pclk);
        end
        rxd <= stop_ok;
        repeat (BIT) @(posedge pclk);
        rxd <= 1'b1;
        repeat (BIT) @(posedge pclk);
    endtask
    // sample the device line at bit middles
    initial begin
        forever begin
            @(posedge pclk);
            if (listen && txd === 1'b0) begin
                repeat (BIT / 2 - 1) @(posedge pclk);
                if (txd !== 1'b0) bad++;
                for (int i = 0; i < 8; i++) begin
                    repeat (BIT) @(posedge pclk);
                    v[i] = txd;
                end
                repeat (2) begin
                    repeat (BIT) @(posedge pclk);
                    if (txd !== 1'b1) bad++;
                end
                got_q.push_back(v);
            end
        end
    end
endmodule
`default_nettype wire

/* bench/async_serial_once_demo_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module async_serial_once_demo_tb;
    localparam string MSG = "Hello world!";
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [4:0]  rxd_pin, txd_pin, txd_pin_oe, gpio_out, gpio_oe, noise;
    logic        tx_done_indicator, rx_done_indicator, rx_error_indicator;
    logic        irq, term_rxd, listen;
    logic [2:0]  sel, ind;
    logic [7:0]  sent [12];
    int          fails, samples_checked;
    assign ind = {rx_error_indicator, rx_done_indicator, tx_done_indicator};
    always_comb begin
        rxd_pin = noise;
        rxd_pin[sel] = term_rxd;
    end
    async_serial_once_demo i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rxd_pin(rxd_pin),
        .txd_pin(txd_pin), .txd_pin_oe(txd_pin_oe), .gpio_out(gpio_out),
        .gpio_oe(gpio_oe), .tx_done_indicator(tx_done_indicator),
        .rx_done_indicator(rx_done_indicator),
        .rx_error_indicator(rx_error_indicator), .irq(irq)
    );
    serial_terminal i_term (
        .pclk(pclk), .txd(txd_pin[sel]), .listen(listen), .rxd(term_rxd)
    );
    task automatic check(input string what, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input int d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 16) begin
            fails++;
            tally_and_finish();
        end
    endtask
    task automatic wait_ind(input logic [2:0] m);
        int n;
        n = 0;
        while ((ind & m) !== m && n < 30000) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 30000) begin
            fails++;
            tally_and_finish();
        end
    endtask
    task automatic do_reset();
        presetn <= 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
    endtask
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    initial begin
        void'($urandom(63));
        {psel, penable, pwrite, paddr, pwdata, sel, listen} = '0;
        {fails, samples_checked} = '0;
        noise = 5'($urandom);
        gpio_out = 5'($urandom);
        gpio_oe = 5'($urandom) & 5'h1E;
        presetn = 1'b0;
        do_reset();
        @(posedge pclk);
        check("idle txd", {txd_pin[0], txd_pin_oe[0]}, 2'b11);
        check("gpio", {txd_pin[4:1], txd_pin_oe[4:1]}, {gpio_out[4:1], gpio_oe[4:1]});
        check("indicators", ind, 3'h0);
        apb(1'b0, 12'h100, 0);
        check("unmapped err", er, 1'b1);
        apb(1'b1, uart_once_pkg::ADDR_CTRL, 7);
        apb(1'b0, uart_once_pkg::ADDR_CTRL, 0);
        check("default channel", rd[2:0], 3'h0);
        $display("test reset_regs done");
        listen <= 1'b1;
        apb(1'b1, uart_once_pkg::ADDR_INT_MSK, 7);
        apb(1'b1, uart_once_pkg::ADDR_CTRL, 32'h100);
        for (int i = 0; i < 12; i++) begin
            sent[i] = 8'($urandom);
            i_term.send(sent[i], 1'b1);
        end
        wait_ind(3'b011);
        check("tx count", i_term.got_q.size(), 12);
        for (int i = 0; i < 12; i++) check("tx byte", i_term.got_q[i], MSG[i]);
        check("tx frames", i_term.bad, 0);
        for (int k = 0; k < 3; k++) begin
            apb(1'b0, uart_once_pkg::ADDR_RXBUF0 + 12'(4 * k), 0);
            check("rx word", rd, {sent[4*k+3], sent[4*k+2], sent[4*k+1], sent[4*k]});
        end
        apb(1'b0, uart_once_pkg::ADDR_STATUS, 0);
        check("status", {rd[11:8], rd[2:0]}, 7'h63);
        check("irq on", irq, 1'b1);
        apb(1'b1, uart_once_pkg::ADDR_INT_MSK, 0);
        @(posedge pclk);
        check("irq masked", irq, 1'b0);
        apb(1'b1, uart_once_pkg::ADDR_INT_MSK, 7);
        apb(1'b1, uart_once_pkg::ADDR_INT_STS, 7);
        @(posedge pclk);
        check("irq cleared", irq, 1'b0);
        $display("test transfer done");
        apb(1'b1, uart_once_pkg::ADDR_CTRL, 32'h100);
        gpio_out <= 5'($urandom);
        repeat (400) @(posedge pclk);
        check("no resend", i_term.got_q.size(), 12);
        check("gpio again", txd_pin[4:1], gpio_out[4:1]);
        $display("test once_only done");
        listen <= 1'b0;
        do_reset();
        sel = 3'(1 + $urandom_range(3));
        apb(1'b1, uart_once_pkg::ADDR_CTRL, 32'h100 | sel);
        for (int i = 0; i < 4; i++) i_term.send(sent[i], i != 2);
        wait_ind(3'b100);
        apb(1'b0, uart_once_pkg::ADDR_STATUS, 0);
        check("err status", {rd[11:8], rd[5], rd[2:1]}, 7'h16);
        check("err flags", rd[2:0], 3'h4);
        apb(1'b0, uart_once_pkg::ADDR_CTRL, 0);
        check("channel", rd[2:0], sel);
        check("no rx done", rx_done_indicator, 1'b0);
        $display("test rx_error done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
